// ==== pkg/srf_pkg.sv ====
// Shared types and constants of the SIMD register file and control/status register
package srf_pkg;
   localparam int NUM_REGS   = 8;
   localparam int REG_W      = 128;
   localparam int IDX_W      = 3;
   localparam int LANE_W     = 32;
   localparam int LANES      = 4;
   localparam int PINT_W     = 64;
   localparam int GPR_W      = 32;
   localparam int BYTES      = 16;
   localparam int CSR_W      = 32;
   // Control/status field positions
   localparam int FLAG_LO    = 0;
   localparam int FLAG_HI    = 5;
   localparam int DAZ_BIT    = 6;
   localparam int MASK_LO    = 7;
   localparam int MASK_HI    = 12;
   localparam int RND_LO     = 13;
   localparam int RND_HI     = 14;
   localparam int FZ_BIT     = 15;
   localparam int RSV_LO     = 16;
   localparam int RSV_HI     = 31;
   localparam logic [31:0] CSR_RESET = 32'h0000_1F80;
   localparam logic [15:0] RSV_ZERO  = 16'h0000;
   // Arithmetic flags register bit positions used for compare outcomes
   localparam int AF_CF_BIT  = 0;
   localparam int AF_PF_BIT  = 2;
   localparam int AF_ZF_BIT  = 6;

   typedef enum logic [1:0] {SRF_W32, SRF_W64, SRF_W128} srf_width_t;
   typedef enum logic [1:0] {SRF_SRC_EXEC, SRF_SRC_MEM, SRF_SRC_GPR, SRF_SRC_PINT} srf_src_t;
   typedef enum logic {SRF_LD_INSTR, SRF_LD_RESTORE} srf_ld_kind_t;

   typedef logic [LANES-1:0][LANE_W-1:0] srf_lanes_t;
   typedef logic [BYTES-1:0][7:0]        srf_bytes_t;

   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx_a;
      logic [IDX_W-1:0] idx_b;
   } srf_rd_req_t;

   typedef struct packed {
      logic             valid;
      logic [IDX_W-1:0] idx;
      srf_width_t       width;
      srf_src_t         src;
      logic [REG_W-1:0] data;
   } srf_wr_req_t;

   typedef struct packed {
      logic             valid;
      srf_ld_kind_t     kind;
      logic [CSR_W-1:0] value;
   } srf_csr_ld_t;

   typedef struct packed {
      logic       valid;
      logic       zf;
      logic       pf;
      logic       cf;
   } srf_cmp_t;

   typedef struct packed {
      logic [5:0] masks;
      logic [1:0] rounding_select_field;
      logic       flush_result_to_zero_bit;
      logic       denormal_input_as_zero_bit;
   } srf_ctrl_t;
endpackage

// ==== hw/srf_csr.sv ====
// Control and status register with sticky flags and reserved-bit fault
`timescale 1ns/100ps
`default_nettype none
module srf_csr (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire srf_pkg::srf_csr_ld_t     ld,
   input  wire logic                     st_req,
   input  wire logic [5:0]               exc_set,
   output logic                          fault,
   output logic [srf_pkg::CSR_W-1:0]     st_data,
   output logic [srf_pkg::CSR_W-1:0]     csr_value
);
   import srf_pkg::*;

   typedef struct packed {
      logic [CSR_W-1:0] csr;
      logic             fault;
      logic [CSR_W-1:0] st;
   } srf_csr_state_t;

   srf_csr_state_t s_q;
   srf_csr_state_t s_d;
   logic           rsv_bad;

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      s_d       = s_q;
      s_d.fault = 1'b0;
      rsv_bad   = (ld.value[RSV_HI:RSV_LO] != RSV_ZERO);
      if (ld.valid) begin
         if (rsv_bad) begin
            s_d.fault = 1'b1;
         end else begin
            s_d.csr = {RSV_ZERO, ld.value[RSV_LO-1:0]};
         end
      end
      // Hardware flag set wins over a clearing load
      s_d.csr[FLAG_HI:FLAG_LO] = s_d.csr[FLAG_HI:FLAG_LO] | exc_set;
      if (st_req) begin
         s_d.st = {RSV_ZERO, s_q.csr[RSV_LO-1:0]};
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '{csr: CSR_RESET, fault: 1'b0, st: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign fault     = s_q.fault;
   assign st_data   = s_q.st;
   assign csr_value = s_q.csr;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_fault_no_update: assert property (ld.valid && ld.value[31:16] != 16'h0000 |=>
      fault && csr_value[15:6] == $past(csr_value[15:6])) else $error("fault load changed csr");
   a_reserved_zero: assert property (csr_value[31:16] == 16'h0000)
      else $error("reserved csr bits nonzero");
   a_flag_sticky: assert property (!ld.valid |=>
      (csr_value[5:0] & $past(csr_value[5:0])) == $past(csr_value[5:0]))
      else $error("sticky flag dropped");
   a_set_wins: assert property (exc_set[0] |=> csr_value[0])
      else $error("flag set lost");
   a_store_upper: assert property (st_req |=> st_data == {16'h0000, $past(csr_value[15:0])})
      else $error("store value wrong");
   a_reset_masks: assert property ($past(sys_rst) |->
      csr_value[12:7] == 6'h3F && !csr_value[15]) else $error("reset masks wrong");
   c_fault_seen: cover property (fault);
   c_restore_ok: cover property (ld.valid && ld.kind == SRF_LD_RESTORE && ld.value[31:16] == 16'h0000);
endmodule
`default_nettype wire

// ==== hw/srf_regfile.sv ====
// Eight 128-bit SIMD data registers with transfer, store and flag ports
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Eight 128-bit data registers chosen by a three-bit index.
// - Own storage; no other register set shares or changes it.
// - Scalar single-precision writes touch only the lowest 32-bit element.
// - No data register value ever leaves as a memory address.
// - Writes and transfers at 32, 64 and 128 bit widths.
// - Full store gives sixteen bytes, register byte zero first.
// - A 32-bit control/status register with flags, masks, rounding, flush, denormal.
// - Control/status loads by instruction or restore, stores by instruction or save.
// - Bits 16 to 31 reserved and cleared at reset.
// - Load with nonzero bits 16 to 31 faults and leaves register unchanged.
// - Compare outcomes go to the arithmetic flags register.
// - Usable in every execution mode; no mode gating.
// - Operands cross to and from the general-purpose registers.
// - 64-bit transfers to and from the packed-integer registers.
// - A 128-bit value is four independent single-precision lanes.
// - Exception flags 0 to 5 stay set until a load clears them.
// - Mask bits 7 to 12 set at reset.
// - Bits 13 and 14 select the rounding mode.
// - Flush-to-zero bit 15 cleared at reset.
module srf_regfile #(
   parameter int NREGS = srf_pkg::NUM_REGS
) (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire srf_pkg::srf_rd_req_t          rd_req,
   input  wire srf_pkg::srf_wr_req_t          wr_req,
   input  wire logic [srf_pkg::GPR_W-1:0]     gpr_rd_data,
   input  wire logic [srf_pkg::PINT_W-1:0]    pint_rd_data,
   input  wire srf_pkg::srf_csr_ld_t          csr_ld,
   input  wire logic                          csr_st_req,
   input  wire logic [5:0]                    exc_set,
   input  wire srf_pkg::srf_cmp_t             cmp_in,
   output logic                               rd_valid,
   output srf_pkg::srf_lanes_t                rd_a_lanes,
   output srf_pkg::srf_lanes_t                rd_b_lanes,
   output logic [srf_pkg::GPR_W-1:0]          gpr_wr_data,
   output logic [srf_pkg::PINT_W-1:0]         pint_wr_data,
   output srf_pkg::srf_bytes_t                mem_store_bytes,
   output logic [srf_pkg::CSR_W-1:0]          csr_st_data,
   output logic                               general_protection_fault,
   output srf_pkg::srf_ctrl_t                 ctrl,
   output logic                               arith_flags_wr,
   output logic [31:0]                        arith_flags_val
);
   import srf_pkg::*;

   typedef struct packed {
      logic [NREGS-1:0][REG_W-1:0] regs;
      logic                        rd_valid;
      logic [REG_W-1:0]            rd_a;
      logic [REG_W-1:0]            rd_b;
      logic                        af_wr;
      logic [31:0]                 af_val;
   } srf_rf_state_t;

   srf_rf_state_t        s_q;
   srf_rf_state_t        s_d;
   logic [REG_W-1:0]     wr_src;
   logic [CSR_W-1:0]     csr_value;

   ////////////////////////////////////////////////////////////////////////
   // Width merge: only the addressed low part of the old value changes
   function automatic logic [REG_W-1:0] merge_width(input logic [REG_W-1:0] old_v,
                                                    input logic [REG_W-1:0] new_v,
                                                    input srf_width_t w);
      logic [REG_W-1:0] r;
      r = old_v;
      case (w)
         SRF_W32:  r[LANE_W-1:0] = new_v[LANE_W-1:0];
         SRF_W64:  r[PINT_W-1:0] = new_v[PINT_W-1:0];
         SRF_W128: r             = new_v;
         default:  r             = old_v;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Source select and next state
   always_comb begin
      case (wr_req.src)
         SRF_SRC_GPR:  wr_src = {{(REG_W-GPR_W){1'b0}}, gpr_rd_data};
         SRF_SRC_PINT: wr_src = {{(REG_W-PINT_W){1'b0}}, pint_rd_data};
         default:      wr_src = wr_req.data;
      endcase
   end

   // Register file update; no mode input gates access
   always_comb begin
      s_d          = s_q;
      s_d.rd_valid = rd_req.valid;
      s_d.af_wr    = cmp_in.valid;
      // Reads see the value before any same-cycle write
      if (rd_req.valid) begin
         s_d.rd_a = s_q.regs[rd_req.idx_a];
         s_d.rd_b = s_q.regs[rd_req.idx_b];
      end
      // Only the addressed register changes, and only the part its width selects
      if (wr_req.valid) begin
         s_d.regs[wr_req.idx] = merge_width(s_q.regs[wr_req.idx], wr_src,
                                            wr_req.width);
      end
      // Compare outcome; flag bits other than CF, PF and ZF read zero
      if (cmp_in.valid) begin
         s_d.af_val             = '0;
         s_d.af_val[AF_ZF_BIT]  = cmp_in.zf;
         s_d.af_val[AF_PF_BIT]  = cmp_in.pf;
         s_d.af_val[AF_CF_BIT]  = cmp_in.cf;
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs: lanes, cross-file transfers, little-endian store image
   assign rd_valid        = s_q.rd_valid;
   assign rd_a_lanes      = srf_lanes_t'(s_q.rd_a);
   assign rd_b_lanes      = srf_lanes_t'(s_q.rd_b);
   assign gpr_wr_data     = s_q.rd_a[GPR_W-1:0];
   assign pint_wr_data    = s_q.rd_a[PINT_W-1:0];
   assign mem_store_bytes = srf_bytes_t'(s_q.rd_a);
   assign arith_flags_wr  = s_q.af_wr;
   assign arith_flags_val = s_q.af_val;

   ////////////////////////////////////////////////////////////////////////
   // Control and status register
   srf_csr u_csr (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ld        (csr_ld),
      .st_req    (csr_st_req),
      .exc_set   (exc_set),
      .fault     (general_protection_fault),
      .st_data   (csr_st_data),
      .csr_value (csr_value)
   );

   // Control fields driven from the live register
   assign ctrl.masks                      = csr_value[MASK_HI:MASK_LO];
   assign ctrl.rounding_select_field      = csr_value[RND_HI:RND_LO];
   assign ctrl.flush_result_to_zero_bit   = csr_value[FZ_BIT];
   assign ctrl.denormal_input_as_zero_bit = csr_value[DAZ_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Write path: width merge, no aliasing, cross-file operands
   a_read_after_write: assert property (wr_req.valid && wr_req.width == SRF_W128 ##1
      !wr_req.valid ##1 rd_req.valid && rd_req.idx_a == $past(wr_req.idx, 2) && !wr_req.valid
      |=> rd_a_lanes == $past(wr_src, 3)) else $error("read after write mismatch");

   a_scalar_upper_kept: assert property (wr_req.valid && wr_req.width == SRF_W32 |=>
      s_q.regs[$past(wr_req.idx)][127:32] == $past(s_q.regs[wr_req.idx][127:32]))
      else $error("scalar write changed upper lanes");

   a_pint_width: assert property (wr_req.valid && wr_req.width == SRF_W64 |=>
      s_q.regs[$past(wr_req.idx)][63:0] == $past(wr_src[63:0]))
      else $error("64-bit write wrong");

   a_no_alias: assert property (wr_req.valid |=>
      s_q.regs[$past(wr_req.idx) ^ 3'h1] == $past(s_q.regs[wr_req.idx ^ 3'h1]))
      else $error("write changed another register");

   a_gpr_operand: assert property (wr_req.valid && wr_req.src == SRF_SRC_GPR |=>
      s_q.regs[$past(wr_req.idx)][31:0] == $past(gpr_rd_data))
      else $error("general register operand lost");

   // Read path: one-cycle valid, held data, lane and byte order
   a_rd_valid_pulse: assert property (rd_valid == $past(rd_req.valid))
      else $error("read valid timing wrong");

   a_read_hold: assert property (!rd_req.valid |=>
      $stable(rd_a_lanes) && $stable(rd_b_lanes)) else $error("read data moved without a read");

   a_lane_order: assert property (rd_valid |->
      rd_a_lanes[0] == $past(s_q.regs[rd_req.idx_a][31:0])
      && rd_a_lanes[3] == $past(s_q.regs[rd_req.idx_a][127:96])) else $error("lane order wrong");

   a_store_bytes: assert property (rd_valid |->
      mem_store_bytes[0] == $past(s_q.regs[rd_req.idx_a][7:0])
      && mem_store_bytes[15] == $past(s_q.regs[rd_req.idx_a][127:120]))
      else $error("store byte order wrong");

   // Compare outcome into the arithmetic flags
   a_cmp_flags: assert property (cmp_in.valid |=> arith_flags_wr &&
      arith_flags_val[6] == $past(cmp_in.zf) && arith_flags_val[0] == $past(cmp_in.cf))
      else $error("compare flags wrong");

   a_flags_rest_zero: assert property (arith_flags_wr |->
      arith_flags_val[31:7] == 25'h0 && arith_flags_val[5:3] == 3'h0 && !arith_flags_val[1])
      else $error("stray arithmetic flag bit");

   // Control fields and fault as seen at the block boundary
   a_rounding_field: assert property (csr_ld.valid && !(|csr_ld.value[31:16]) |=>
      ctrl.rounding_select_field == $past(csr_ld.value[14:13]))
      else $error("rounding field mismatch");

   a_ctrl_reset: assert property ($past(sys_rst) |-> ctrl.masks == 6'h3F
      && !ctrl.flush_result_to_zero_bit && !ctrl.denormal_input_as_zero_bit
      && ctrl.rounding_select_field == 2'h0) else $error("control fields wrong after reset");

   a_fault_pulse: assert property (general_protection_fault ==
      ($past(csr_ld.valid) && $past(csr_ld.value[31:16]) != 16'h0000))
      else $error("fault pulse wrong");

   // Main scenarios
   c_full_write: cover property (wr_req.valid && wr_req.width == SRF_W128);
   c_gpr_xfer: cover property (wr_req.valid && wr_req.src == SRF_SRC_GPR);
   c_cmp: cover property (arith_flags_wr);
endmodule
`default_nettype wire

// ==== tb/srf_pipe_model.sv ====
// Execution pipeline stand-in that supplies operands from the other register files
`timescale 1ns/100ps
`default_nettype none
module srf_pipe_model #(
   parameter logic [31:0] GPR_VAL  = 32'hA5C3_0F12,
   parameter logic [63:0] PINT_VAL = 64'h1357_9BDF_2468_ACE0
) (
   output logic [31:0] gpr_rd_data,
   output logic [63:0] pint_rd_data
);
   // Operands held steady, as a register file read port would hold them
   assign gpr_rd_data  = GPR_VAL;
   assign pint_rd_data = PINT_VAL;
endmodule
`default_nettype wire

// ==== tb/srf_regfile_test.sv ====
// Self-checking bench of the SIMD register file and control/status register
`timescale 1ns/100ps
`default_nettype none
module srf_regfile_test;
   import srf_pkg::*;
   localparam logic [127:0] VA = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
   localparam logic [127:0] VB = 128'hFFEEDDCC_BBAA9988_77665544_33221100;
   logic          clk, sys_rst, csr_st_req, rd_valid, general_protection_fault, arith_flags_wr;
   srf_rd_req_t   rd_req;
   srf_wr_req_t   wr_req;
   srf_csr_ld_t   csr_ld;
   srf_cmp_t      cmp_in;
   logic [5:0]    exc_set;
   logic [31:0]   gpr_rd_data, gpr_wr_data, csr_st_data, arith_flags_val;
   logic [63:0]   pint_rd_data, pint_wr_data;
   srf_lanes_t    rd_a_lanes, rd_b_lanes;
   srf_bytes_t    mem_store_bytes;
   srf_ctrl_t     ctrl;
   int            fail_count, samples_checked, cycles;
   ////////////////////////////////////////////////////////////////////////
   // Design and partner
   srf_regfile uut (.clk(clk), .sys_rst(sys_rst), .rd_req(rd_req), .wr_req(wr_req),
      .gpr_rd_data(gpr_rd_data), .pint_rd_data(pint_rd_data), .csr_ld(csr_ld),
      .csr_st_req(csr_st_req), .exc_set(exc_set), .cmp_in(cmp_in), .rd_valid(rd_valid),
      .rd_a_lanes(rd_a_lanes), .rd_b_lanes(rd_b_lanes), .gpr_wr_data(gpr_wr_data),
      .pint_wr_data(pint_wr_data), .mem_store_bytes(mem_store_bytes),
      .csr_st_data(csr_st_data), .general_protection_fault(general_protection_fault),
      .ctrl(ctrl), .arith_flags_wr(arith_flags_wr), .arith_flags_val(arith_flags_val));
   srf_pipe_model pipe (.gpr_rd_data(gpr_rd_data), .pint_rd_data(pint_rd_data));
   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [2:0] i, input srf_width_t w, input srf_src_t s,
                     input logic [127:0] d);
      @(posedge clk);
      wr_req <= '{1'b1, i, w, s, d};
      @(posedge clk);
      wr_req.valid <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [2:0] b, input logic [127:0] ea,
                     input logic [127:0] eb);
      @(posedge clk);
      rd_req <= '{1'b1, a, b};
      @(posedge clk);
      rd_req.valid <= 1'b0;
      #1;
      chk("rd_valid", 128'h1, 128'(rd_valid));
      chk("rd_a", ea, rd_a_lanes);
      chk("rd_b", eb, rd_b_lanes);
      chk("gpr_out", 128'(ea[31:0]), 128'(gpr_wr_data));
      chk("pint_out", 128'(ea[63:0]), 128'(pint_wr_data));
      chk("store_bytes", ea, mem_store_bytes);
   endtask
   task automatic st(input logic [31:0] e);
      @(posedge clk);
      csr_st_req <= 1'b1;
      @(posedge clk);
      csr_st_req <= 1'b0;
      #1;
      chk("csr_store", 128'(e), 128'(csr_st_data));
   endtask
   task automatic ld(input srf_ld_kind_t k, input logic [31:0] v, input logic f);
      @(posedge clk);
      csr_ld <= '{1'b1, k, v};
      @(posedge clk);
      csr_ld.valid <= 1'b0;
      #1;
      chk("fault", 128'(f), 128'(general_protection_fault));
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      st(32'h0000_1F80);
      chk("ctrl", 128'h3F0, 128'(ctrl));
      rd(3'h0, 3'h7, '0, '0);
   endtask
   task automatic t_widths();
      wr(3'h0, SRF_W128, SRF_SRC_EXEC, VA);
      wr(3'h7, SRF_W128, SRF_SRC_MEM, VB);
      rd(3'h7, 3'h0, VB, VA);
      wr(3'h7, SRF_W32, SRF_SRC_EXEC, ~VA);
      rd(3'h7, 3'h0, {VB[127:32], ~VA[31:0]}, VA);
      wr(3'h7, SRF_W64, SRF_SRC_PINT, VA);
      rd(3'h7, 3'h0, {VB[127:64], pint_rd_data}, VA);
      wr(3'h5, SRF_W32, SRF_SRC_GPR, VA);
      rd(3'h5, 3'h7, {96'h0, gpr_rd_data}, {VB[127:64], pint_rd_data});
   endtask
   task automatic t_csr();
      ld(SRF_LD_RESTORE, 32'h0001_6000, 1'b1);
      ld(SRF_LD_INSTR, 32'h8000_0000, 1'b1);
      st(32'h0000_1F80);
      ld(SRF_LD_INSTR, 32'h0000_E040, 1'b0);
      chk("ctrl", 128'h00F, 128'(ctrl));
      st(32'h0000_E040);
      ld(SRF_LD_RESTORE, 32'h0000_3F80, 1'b0);
      chk("rounding", 128'h1, 128'(ctrl.rounding_select_field));
   endtask
   task automatic t_sticky();
      @(posedge clk);
      exc_set <= 6'h21;
      @(posedge clk);
      exc_set <= 6'h00;
      st(32'h0000_3FA1);
      st(32'h0000_3FA1);
      ld(SRF_LD_INSTR, 32'h0000_1F80, 1'b0);
      st(32'h0000_1F80);
      // Flag event and clearing load in one cycle: the set wins
      @(posedge clk);
      exc_set <= 6'h04;
      csr_ld  <= '{1'b1, SRF_LD_INSTR, 32'h0000_1F80};
      @(posedge clk);
      exc_set <= 6'h00;
      csr_ld.valid <= 1'b0;
      st(32'h0000_1F84);
   endtask
   task automatic t_cmp();
      @(posedge clk);
      cmp_in <= '{1'b1, 1'b1, 1'b0, 1'b1};
      @(posedge clk);
      cmp_in.valid <= 1'b0;
      #1;
      chk("flags_wr", 128'h1, 128'(arith_flags_wr));
      chk("flags_val", 128'h41, 128'(arith_flags_val));
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Clock, timeout and main sequence
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         close_out();
      end
   end
   initial begin
      sys_rst = 1'b1;
      rd_req = '0;
      wr_req = '0;
      csr_ld = '0;
      csr_st_req = 1'b0;
      exc_set = 6'h00;
      cmp_in = '0;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_widths();
      t_csr();
      t_sticky();
      t_cmp();
      close_out();
   end
endmodule
`default_nettype wire
